/* File: inc/remote_ctrl_pkg.sv */
// Shared constants, modes and carrier types for the remote command logic.
// Assumes one 40 MHz clock and command inputs already isolated to logic levels.
package remote_ctrl_pkg;

  // ***********************************************************************
  // Clock and timing
  // ***********************************************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_TIME_US;
  localparam int unsigned HOLD_TIME_MS = 300;
  localparam int unsigned HOLD_TICKS = (HOLD_TIME_MS * 1000) / TICK_TIME_US;
  localparam int unsigned LEVEL_TIME_MS = 10;
  localparam int unsigned LEVEL_TICKS = (LEVEL_TIME_MS * 1000) / TICK_TIME_US;
  localparam int unsigned INIT_TIME_MS = 5000;
  localparam int unsigned INIT_TICKS = (INIT_TIME_MS * 1000) / TICK_TIME_US;

  localparam int TICK_CNT_W = 16;
  localparam int INIT_CNT_W = 16;
  localparam int QUAL_CNT_W = 12;
  localparam int COOLER_NUM = 2;

  // ***********************************************************************
  // Reset values
  // ***********************************************************************
  localparam logic [TICK_CNT_W-1:0] TICK_CNT_RST = 16'h0000;
  localparam logic [INIT_CNT_W-1:0] INIT_CNT_RST = 16'h0000;
  localparam logic [QUAL_CNT_W-1:0] QUAL_CNT_RST = 12'h000;

  // ***********************************************************************
  // Types
  // ***********************************************************************
  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_MOMENTARY = 2'b01,
    MODE_ALTERNATE = 2'b10
  } mode_t;

  typedef struct packed {
    logic start;
    logic stop_hold;
    logic onoff;
    logic [COOLER_NUM-1:0] cooler_run_cmd;
  } cmd_t;

  typedef struct packed {
    logic pump_answer_contact;
    logic [COOLER_NUM-1:0] cooler_answer_contact;
    logic fault_contact;
  } answer_t;

endpackage

/* File: rtl/cmd_qualifier.sv */
// Synchroniser and hold-time qualifier for one isolated command input.
// Assumes a one-cycle tick enable pulse from the parent's divider.
`timescale 1ns/100ps
module cmd_qualifier
  import remote_ctrl_pkg::*;
#(
  parameter int unsigned HOLD = 1
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic tick_in,
  input wire logic raw_in,
  output logic level_out
);

  logic sync1_r;
  logic sync2_r;
  logic level_r;
  logic level_nxt;
  logic [QUAL_CNT_W-1:0] cnt_r;
  logic [QUAL_CNT_W-1:0] cnt_nxt;

  // ***********************************************************************
  // Hold-time counter
  // ***********************************************************************
  always_comb
  begin
    level_nxt = level_r;
    cnt_nxt = cnt_r;
    if (sync2_r == level_r)
    begin
      cnt_nxt = QUAL_CNT_RST;
    end
    else if (tick_in)
    begin
      if (cnt_r >= QUAL_CNT_W'(HOLD - 1))
      begin
        level_nxt = sync2_r;
        cnt_nxt = QUAL_CNT_RST;
      end
      else
      begin
        cnt_nxt = cnt_r + QUAL_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      level_r <= 1'b0;
      cnt_r <= QUAL_CNT_RST;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign level_out = level_r;

endmodule // cmd_qualifier

/* File: rtl/remote_cmd_ctrl.sv */
// Remote command interpreter for a compressor pump with two coolers.
// Assumes level inputs from isolated couplers, a fault level from the
// protection logic and a manual reset button level, all on clk_in.
`timescale 1ns/100ps
module remote_cmd_ctrl
  import remote_ctrl_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned INIT_LEN = INIT_TICKS
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire cmd_t cmd_in,
  input wire logic fault_in,
  input wire logic fault_reset_in,
  output answer_t answer_out,
  output logic pump_run_out,
  output logic [COOLER_NUM-1:0] cooler_run_out,
  output mode_t mode_out
);

  logic [TICK_CNT_W-1:0] tick_cnt_r;
  logic [TICK_CNT_W-1:0] tick_cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [INIT_CNT_W-1:0] init_cnt_r;
  logic [INIT_CNT_W-1:0] init_cnt_nxt;
  logic ready_r;
  logic ready_nxt;
  mode_t mode_r;
  mode_t mode_nxt;
  logic pump_r;
  logic pump_nxt;
  logic [COOLER_NUM-1:0] cooler_r;
  logic [COOLER_NUM-1:0] cooler_nxt;
  logic fault_r;
  logic fault_nxt;
  answer_t answer_r;
  answer_t answer_nxt;
  logic start_q;
  logic stop_hold_q;
  logic onoff_q;
  logic [COOLER_NUM-1:0] cooler_q;

  // ***********************************************************************
  // Tick divider and power-up initialisation
  // ***********************************************************************
  always_comb
  begin
    tick_cnt_nxt = tick_cnt_r + TICK_CNT_W'(1);
    tick_nxt = 1'b0;
    if (tick_cnt_r >= TICK_CNT_W'(TICK_LEN - 1))
    begin
      tick_cnt_nxt = TICK_CNT_RST;
      tick_nxt = 1'b1;
    end
    init_cnt_nxt = init_cnt_r;
    ready_nxt = ready_r;
    if (!ready_r && tick_r)
    begin
      if (init_cnt_r >= INIT_CNT_W'(INIT_LEN - 1))
      begin
        ready_nxt = 1'b1;
      end
      else
      begin
        init_cnt_nxt = init_cnt_r + INIT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      tick_cnt_r <= TICK_CNT_RST;
      tick_r <= 1'b0;
      init_cnt_r <= INIT_CNT_RST;
      ready_r <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
      init_cnt_r <= init_cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ***********************************************************************
  // Input qualification
  // ***********************************************************************
  cmd_qualifier #(.HOLD(HOLD_TICKS)) u_start_qual (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tick_in(tick_r),
    .raw_in(cmd_in.start),
    .level_out(start_q)
  );

  cmd_qualifier #(.HOLD(HOLD_TICKS)) u_stop_qual (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tick_in(tick_r),
    .raw_in(cmd_in.stop_hold),
    .level_out(stop_hold_q)
  );

  cmd_qualifier #(.HOLD(LEVEL_TICKS)) u_onoff_qual (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .tick_in(tick_r),
    .raw_in(cmd_in.onoff),
    .level_out(onoff_q)
  );

  genvar gi;
  generate
    for (gi = 0; gi < COOLER_NUM; gi++)
    begin : g_cooler_qual
      cmd_qualifier #(.HOLD(LEVEL_TICKS)) u_cooler_qual (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .tick_in(tick_r),
        .raw_in(cmd_in.cooler_run_cmd[gi]),
        .level_out(cooler_q[gi])
      );
    end
  endgenerate

  // ***********************************************************************
  // Mode, pump, coolers and fault latch
  // ***********************************************************************
  always_comb
  begin
    mode_nxt = mode_r;
    pump_nxt = pump_r;
    cooler_nxt = cooler_r;
    fault_nxt = fault_r;
    if (fault_reset_in && !fault_in)
    begin
      fault_nxt = 1'b0;
    end
    if (fault_in)
    begin
      fault_nxt = 1'b1;
    end
    if (ready_r)
    begin
      unique case (mode_r)
        MODE_NONE:
        begin
          // Start wins if both commands qualify together
          if (start_q)
          begin
            mode_nxt = MODE_MOMENTARY;
          end
          else if (onoff_q)
          begin
            mode_nxt = MODE_ALTERNATE;
          end
          pump_nxt = 1'b0;
        end
        MODE_MOMENTARY:
        begin
          if (!stop_hold_q)
          begin
            pump_nxt = 1'b0;
          end
          else if (start_q)
          begin
            pump_nxt = 1'b1;
          end
        end
        MODE_ALTERNATE:
        begin
          pump_nxt = onoff_q;
        end
        default:
        begin
          mode_nxt = MODE_NONE;
          pump_nxt = 1'b0;
        end
      endcase
      if (fault_r)
      begin
        pump_nxt = 1'b0;
      end
      cooler_nxt = pump_nxt ? cooler_q : '0;
    end
  end

  // ***********************************************************************
  // Answer-back contacts
  // ***********************************************************************
  always_comb
  begin
    answer_nxt = '0;
    if (ready_r)
    begin
      answer_nxt.pump_answer_contact = pump_r;
      answer_nxt.cooler_answer_contact = cooler_r & {COOLER_NUM{pump_r}};
      answer_nxt.fault_contact = fault_r;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mode_r <= MODE_NONE;
      pump_r <= 1'b0;
      cooler_r <= '0;
      fault_r <= 1'b0;
      answer_r <= '0;
    end
    else
    begin
      mode_r <= mode_nxt;
      pump_r <= pump_nxt;
      cooler_r <= cooler_nxt;
      fault_r <= fault_nxt;
      answer_r <= answer_nxt;
    end
  end

  assign answer_out = answer_r;
  assign pump_run_out = pump_r;
  assign cooler_run_out = cooler_r;
  assign mode_out = mode_r;

endmodule // remote_cmd_ctrl

/* File: sim/remote_cmd_ctrl_monitor.sv */
// Port checks for the remote command controller.
// Assumes one clock domain; bound to every instance.
`timescale 1ns/100ps
module remote_cmd_ctrl_monitor
  import remote_ctrl_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned INIT_LEN = INIT_TICKS
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire cmd_t cmd_in,
  input wire logic fault_in,
  input wire logic fault_reset_in,
  input wire answer_t answer_out,
  input wire logic pump_run_out,
  input wire logic [COOLER_NUM-1:0] cooler_run_out,
  input wire mode_t mode_out
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  int unsigned low_r;
  int unsigned low_nxt;
  always_comb
  begin
    low_nxt = cmd_in.stop_hold ? 0 : low_r + 1;
  end
  always_ff @(posedge clk_in)
  begin
    low_r <= srst_in ? 0 : low_nxt;
  end
  mode_legal_a: assert property (
    mode_out inside {MODE_NONE, MODE_MOMENTARY, MODE_ALTERNATE})
    else $error("illegal mode");
  mode_fixed_a: assert property (mode_out != MODE_NONE |=> $stable(mode_out))
    else $error("mode changed");
  init_quiet_a: assert property ($fell(srst_in) |->
    (answer_out == '0 && !pump_run_out)[*8])
    else $error("output during init");
  cool_gate_a: assert property (!pump_run_out |-> cooler_run_out == '0)
    else $error("cooler without pump");
  pump_ans_a: assert property ($rose(pump_run_out) |=> answer_out.pump_answer_contact)
    else $error("pump answer missing");
  cool_ans_a: assert property ($rose(cooler_run_out[0]) |=>
    answer_out.cooler_answer_contact[0])
    else $error("cooler answer missing");
  stop_hold_a: assert property (mode_out == MODE_MOMENTARY &&
    low_r > (HOLD_TICKS + 2) * TICK_LEN + 4 |-> !pump_run_out)
    else $error("pump not stopped");
  fault_set_a: assert property (fault_in && mode_out != MODE_NONE |->
    ##[1:4] answer_out.fault_contact)
    else $error("fault contact open");
  fault_keep_a: assert property (answer_out.fault_contact && !$past(fault_reset_in) |=>
    answer_out.fault_contact)
    else $error("fault contact dropped");
  cover property (pump_run_out && mode_out == MODE_MOMENTARY);
  cover property (pump_run_out && mode_out == MODE_ALTERNATE);
  cover property (answer_out.fault_contact);
endmodule // remote_cmd_ctrl_monitor

bind remote_cmd_ctrl remote_cmd_ctrl_monitor #(.TICK_LEN(TICK_LEN), .INIT_LEN(INIT_LEN)) i_mon (
  .clk_in(clk_in), .srst_in(srst_in), .cmd_in(cmd_in), .fault_in(fault_in),
  .fault_reset_in(fault_reset_in), .answer_out(answer_out), .pump_run_out(pump_run_out),
  .cooler_run_out(cooler_run_out), .mode_out(mode_out));

/* File: sim/equip_model.sv */
// Equipment-side controller model driving the command lines.
// Assumes the bench gives wanted levels; lines change at the falling edge.
`timescale 1ns/100ps
module equip_model
  import remote_ctrl_pkg::*;
(
  input wire logic clk_in,
  input wire mode_t use_in,
  input wire logic run_in,
  input wire logic stop_in,
  input wire logic [COOLER_NUM-1:0] cool_in,
  output cmd_t cmd_out
);
  always @(negedge clk_in)
  begin
    cmd_out.onoff <= use_in == MODE_ALTERNATE && run_in;
    cmd_out.start <= use_in == MODE_MOMENTARY && run_in && !stop_in;
    cmd_out.stop_hold <= use_in == MODE_MOMENTARY && !(stop_in && !cmd_out.start);
    cmd_out.cooler_run_cmd <= cool_in;
  end
endmodule // equip_model

/* File: sim/remote_cmd_ctrl_test.sv */
// Self-checking bench for the remote command controller.
// Assumes shortened tick (4 cycles) and init (3 ticks) lengths.
`timescale 1ns/100ps
module remote_cmd_ctrl_test;
  import remote_ctrl_pkg::*;
  localparam int TL = 4;
  localparam int HC = (HOLD_TICKS + 4) * TL;
  localparam int LC = (LEVEL_TICKS + 4) * TL;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic fault_in = 1'b0;
  logic fault_reset_in = 1'b0;
  mode_t use_m = MODE_ALTERNATE;
  logic run = 1'b0;
  logic stop = 1'b0;
  logic [1:0] cool = 2'h0;
  logic [1:0] rc;
  cmd_t cmd;
  answer_t answer;
  logic pump;
  logic [1:0] cooler;
  mode_t mode;
  logic [8:0] exp_q[$];
  logic chk = 1'b0;
  int num_errors = 0;
  int checks = 0;
  int seed = 96;
  int cycles = 0;
  always #12.5 clk_in = ~clk_in;
  equip_model i_equip_model (.clk_in(clk_in), .use_in(use_m), .run_in(run), .stop_in(stop),
    .cool_in(cool), .cmd_out(cmd));
  remote_cmd_ctrl #(.TICK_LEN(TL), .INIT_LEN(3)) i_remote_cmd_ctrl (.clk_in(clk_in),
    .srst_in(srst_in), .cmd_in(cmd), .fault_in(fault_in), .fault_reset_in(fault_reset_in),
    .answer_out(answer), .pump_run_out(pump), .cooler_run_out(cooler), .mode_out(mode));
  // ****
  // Tasks and watcher
  // ****
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic drive(input logic r, input logic s, input logic [1:0] c, input int n);
    run <= r;
    stop <= s;
    cool <= c;
    repeat (n) @(negedge clk_in);
  endtask
  task automatic expect_out(input mode_t m, input logic p, input logic [1:0] c, input logic f);
    exp_q.push_back({m, p, c & {2{p}}, p, c & {2{p}}, f});
    chk = 1'b1;
    @(negedge clk_in);
    chk = 1'b0;
  endtask
  task automatic power_up(input mode_t m);
    use_m <= m;
    srst_in = 1'b1;
    repeat (16) @(negedge clk_in);
    srst_in = 1'b0;
    expect_out(MODE_NONE, 1'b0, 2'h0, 1'b0);
    drive(1'b0, 1'b0, 2'h3, HC);
  endtask
  always @(posedge clk_in)
    if (chk)
    begin
      checks++;
      if ({mode, pump, cooler, answer} !== exp_q[0])
      begin
        num_errors++;
        $display("MISMATCH %0t exp %h got %h", $time, exp_q[0], {mode, pump, cooler, answer});
      end
      void'(exp_q.pop_front());
    end
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      num_errors++;
      test_done();
    end
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    power_up(MODE_ALTERNATE);
    expect_out(MODE_NONE, 1'b0, 2'h3, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      rc = 2'($random(seed));
      drive(1'b1, 1'b0, rc, LC);
      expect_out(MODE_ALTERNATE, 1'b1, rc, 1'b0);
    end
    drive(1'b0, 1'b0, rc, 5 * TL);
    drive(1'b1, 1'b0, rc, LC);
    expect_out(MODE_ALTERNATE, 1'b1, rc, 1'b0);
    fault_in = 1'b1;
    drive(1'b1, 1'b0, rc, 6);
    fault_in = 1'b0;
    drive(1'b1, 1'b0, rc, 10);
    expect_out(MODE_ALTERNATE, 1'b0, rc, 1'b1);
    fault_reset_in = 1'b1;
    drive(1'b1, 1'b0, rc, 2);
    fault_reset_in = 1'b0;
    drive(1'b1, 1'b0, rc, LC);
    expect_out(MODE_ALTERNATE, 1'b1, rc, 1'b0);
    drive(1'b0, 1'b0, rc, LC);
    expect_out(MODE_ALTERNATE, 1'b0, rc, 1'b0);
    use_m <= MODE_MOMENTARY;
    drive(1'b1, 1'b0, 2'h0, HC);
    expect_out(MODE_ALTERNATE, 1'b0, 2'h0, 1'b0);
    $display("alternate test done");
    fault_in = 1'b1;
    power_up(MODE_MOMENTARY);
    expect_out(MODE_NONE, 1'b0, 2'h0, 1'b1);
    fault_in = 1'b0;
    fault_reset_in = 1'b1;
    drive(1'b0, 1'b0, 2'h3, 2);
    fault_reset_in = 1'b0;
    drive(1'b1, 1'b0, 2'h3, HC);
    drive(1'b0, 1'b0, 2'h3, HC);
    expect_out(MODE_MOMENTARY, 1'b1, 2'h3, 1'b0);
    drive(1'b0, 1'b1, 2'h3, 100 * TL);
    drive(1'b0, 1'b0, 2'h1, HC);
    expect_out(MODE_MOMENTARY, 1'b1, 2'h1, 1'b0);
    drive(1'b0, 1'b1, 2'h3, HC);
    expect_out(MODE_MOMENTARY, 1'b0, 2'h3, 1'b0);
    $display("momentary test done");
    test_done();
  end
endmodule // remote_cmd_ctrl_test
